// file: inc/sip_pkg.sv
// package for the serial programming page access block
// Summary of operation
// [R1] protected lock mode refuses signature byte reads
// [R2] two select bits encode four lock modes
// [R3] lock modes one to three precede mode four
// [R4] programmer holds clock low 64 cycles first
// [R5] session starts with reset held high only
// [R6] serial clock at most one sixteenth system
// [R7] page bytes run offset zero to 255
// [R8] after command and address, bytes are data
// [R9] after byte 256, decode next instruction
// [R10] clock high and low eight periods each
// [R11] chip erase completes within 500 ms
// [R12] byte write within 64 periods plus 400 us
// [R13] page read command is 0x30
// [R14] page write command is 0x50
// [R15] msb first, sample rising, change after falling
package sip_pkg;
    localparam int unsigned CLK_HZ = 40000000;
    localparam int unsigned ERASE_MS = 500;
    localparam int unsigned ERASE_CYC = ERASE_MS * (CLK_HZ / 1000);
    localparam int unsigned SWC_PERIODS = 64;
    localparam int unsigned SWC_US = 400;
    localparam int unsigned SWC_CYC = SWC_PERIODS + SWC_US * (CLK_HZ / 1000000);
    localparam int unsigned PAGE_BYTES = 256;
    localparam logic [7:0] CMD_PAGE_RD = 8'h30;
    localparam logic [7:0] CMD_PAGE_WR = 8'h50;
    localparam logic [7:0] CMD_SIG_RD = 8'h28;
    localparam logic [7:0] CMD_ERASE = 8'hAC;
    localparam logic [7:0] CMD_BYTE_WR = 8'h40;
    localparam logic [7:0] CMD_BYTE_RD = 8'h20;
    localparam logic [7:0] CMD_LOCK = 8'h24;
    localparam logic [7:0] SIG_DENIED = 8'hFF;
    typedef enum logic [2:0] {
        SIP_CMD = 3'b000,
        SIP_ADH = 3'b001,
        SIP_ADL = 3'b011,
        SIP_DAT = 3'b010,
        SIP_BUSY = 3'b110
    } sip_state_e;
    typedef struct packed {
        logic req;
        logic wr;
        logic erase;
        logic [12:0] addr;
        logic [7:0] wdata;
    } sip_mem_s;
endpackage

// file: hw/sip_shifter.sv
// byte shifter for the serial link
`timescale 1ns/1ps
`default_nettype none
module sip_shifter (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    // synchronised link
    input wire logic sck_rise_i,
    input wire logic sck_fall_i,
    input wire logic mosi_i,
    // byte interface
    input wire logic load_i,
    input wire logic [7:0] tx_byte_i,
    output logic [7:0] rx_byte_o,
    output logic rx_done_o,
    output logic miso_o
);
    logic [7:0] sh_q;
    logic [7:0] tx_q;
    logic [2:0] cnt_q;
    logic done_q;
    logic miso_q;
    wire [7:0] sh_d = {sh_q[6:0], mosi_i}; // see [R15]
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i == 1'b0) begin
            sh_q <= 8'h00;
            cnt_q <= 3'h0;
            done_q <= 1'b0;
        end else if (sck_rise_i) begin
            sh_q <= sh_d;
            cnt_q <= cnt_q + 3'h1;
            done_q <= (cnt_q == 3'h7);
        end else begin
            done_q <= 1'b0;
        end
    end
    // next bit goes out after the falling edge so the host samples it stable
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i == 1'b0) begin
            tx_q <= 8'h00;
            miso_q <= 1'b0;
        end else if (load_i) begin
            tx_q <= tx_byte_i;
        end else if (sck_fall_i) begin
            miso_q <= tx_q[7]; // see [R15]
            tx_q <= {tx_q[6:0], 1'b0};
        end
    end
    assign rx_byte_o = sh_q;
    assign rx_done_o = done_q;
    assign miso_o = miso_q;
endmodule
`default_nettype wire

// file: hw/sip_page_access.sv
// serial programming port with page mode access
`timescale 1ns/1ps
`default_nettype none
module sip_page_access
    import sip_pkg::*;
#(
    parameter int unsigned ERASE_CYCLES = ERASE_CYC,
    parameter int unsigned WRITE_CYCLES = SWC_CYC
) (
    // clock and reset; reset high is programming enable
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    // serial link pins
    input wire logic sck_i,
    input wire logic mosi_i,
    output logic miso_o,
    // lock mode selection
    input wire logic lock_mode_select_hi_i,
    input wire logic lock_mode_select_lo_i,
    // flash array port
    output sip_mem_s mem_o,
    input wire logic [7:0] mem_rdata_i,
    input wire logic [7:0] signature_i,
    // status
    output logic busy_o,
    output logic sig_refused_o,
    output logic [1:0] lock_level_o
);
    logic [2:0] sck_sync_q;
    logic [1:0] mosi_sync_q;
    logic [3:0] lk_sync_q;
    sip_state_e state_q;
    logic [7:0] cmd_q;
    logic [4:0] adh_q;
    logic [7:0] idx_q;
    logic [1:0] lock_q;
    logic [1:0] seq_q;
    logic [25:0] wait_q;
    logic load_q;
    logic refused_q;
    sip_mem_s mem_q;
    logic [7:0] rx_byte;
    logic rx_done;
    // link pins pass two flops; the third stage finds edges
    always_ff @(posedge ref_clk_i) begin
        sck_sync_q <= {sck_sync_q[1:0], sck_i};
        mosi_sync_q <= {mosi_sync_q[0], mosi_i};
        lk_sync_q <= {lk_sync_q[1:0], lock_mode_select_hi_i, lock_mode_select_lo_i};
    end
    // edge detect relies on the host keeping eight periods per phase
    wire sck_rise = sck_sync_q[1] & ~sck_sync_q[2]; // see [R6] see [R10]
    wire sck_fall = ~sck_sync_q[1] & sck_sync_q[2];
    // both clear none, lo set mode 2, hi set mode 3, both mode 4
    wire [1:0] lock_req = lk_sync_q[3:2]; // see [R2]
    wire is_page = (cmd_q == CMD_PAGE_RD) || (cmd_q == CMD_PAGE_WR); // see [R13] see [R14]
    wire page_end = (idx_q == 8'(PAGE_BYTES - 1)); // see [R7]
    wire sig_block = (lock_q != 2'b00); // see [R1]
    // picked in the load cycle so the shifter never takes a stale byte
    wire [7:0] tx_pick = ((cmd_q == CMD_SIG_RD) && sig_block) ? SIG_DENIED :
                         (cmd_q == CMD_SIG_RD) ? signature_i : mem_rdata_i; // see [R1]
    sip_shifter u_shift (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .sck_rise_i(sck_rise),
        .sck_fall_i(sck_fall),
        .mosi_i(mosi_sync_q[1]),
        .load_i(load_q),
        .tx_byte_i(tx_pick),
        .rx_byte_o(rx_byte),
        .rx_done_o(rx_done),
        .miso_o(miso_o)
    );
    // reset held high is the only entry condition; low idles the port
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i == 1'b0) begin // see [R5]
            state_q <= SIP_CMD;
            cmd_q <= 8'h00;
            adh_q <= 5'h00;
            idx_q <= 8'h00;
            wait_q <= 26'h0;
            load_q <= 1'b0;
            refused_q <= 1'b0;
            mem_q <= '0;
        end else begin
            load_q <= 1'b0;
            mem_q.req <= 1'b0;
            unique case (state_q)
                SIP_CMD: begin
                    if (rx_done) begin
                        cmd_q <= rx_byte;
                        state_q <= (rx_byte == CMD_ERASE) ? SIP_BUSY : SIP_ADH;
                        if (rx_byte == CMD_ERASE) begin
                            wait_q <= 26'(ERASE_CYCLES); // see [R11]
                            mem_q.req <= 1'b1;
                            mem_q.erase <= 1'b1;
                            mem_q.wr <= 1'b0;
                        end
                    end
                end
                SIP_ADH: begin
                    if (rx_done) begin
                        adh_q <= rx_byte[4:0];
                        idx_q <= 8'h00; // see [R7]
                        state_q <= is_page ? SIP_DAT : SIP_ADL; // see [R8]
                        if (cmd_q == CMD_PAGE_RD) begin
                            mem_q <= '{1'b1, 1'b0, 1'b0, {rx_byte[4:0], 8'h00}, 8'h00};
                        end
                    end
                end
                SIP_ADL: begin
                    if (rx_done) begin
                        idx_q <= rx_byte;
                        state_q <= SIP_DAT;
                        mem_q <= '{1'b1, 1'b0, 1'b0, {adh_q, rx_byte}, 8'h00};
                        if (cmd_q == CMD_SIG_RD) begin
                            refused_q <= sig_block; // see [R1]
                        end
                    end
                end
                SIP_DAT: begin
                    if (rx_done) begin
                        idx_q <= idx_q + 8'h01;
                        if (cmd_q == CMD_PAGE_WR || cmd_q == CMD_BYTE_WR) begin
                            mem_q <= '{1'b1, 1'b1, 1'b0, {adh_q, idx_q}, rx_byte};
                        end else if (cmd_q == CMD_PAGE_RD && !page_end) begin
                            mem_q <= '{1'b1, 1'b0, 1'b0, {adh_q, idx_q + 8'h01}, 8'h00};
                        end
                        if (!is_page) begin
                            state_q <= (cmd_q == CMD_BYTE_WR) ? SIP_BUSY : SIP_CMD;
                            wait_q <= 26'(WRITE_CYCLES); // see [R12]
                        end else if (page_end) begin
                            state_q <= SIP_CMD; // see [R9]
                        end
                    end else if (mem_q.req && !mem_q.wr) begin
                        // read data loads one cycle after the array request
                        load_q <= 1'b1;
                    end
                end
                SIP_BUSY: begin
                    mem_q.erase <= 1'b0;
                    if (wait_q == 26'h0) begin
                        state_q <= SIP_CMD;
                    end else begin
                        wait_q <= wait_q - 26'h1;
                    end
                end
                default: state_q <= SIP_CMD;
            endcase
        end
    end
    // lock level only climbs one step at a time; a skip is ignored
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i == 1'b0) begin
            lock_q <= 2'b00;
            seq_q <= 2'b00;
        end else if (state_q == SIP_ADH && rx_done && cmd_q == CMD_LOCK) begin
            if (lock_req == 2'b11) begin
                if (seq_q == 2'b10) begin // see [R3]
                    lock_q <= 2'b11;
                    seq_q <= 2'b11;
                end
            end else if (lock_req != 2'b00 && {1'b0, lock_req[1]} == seq_q) begin
                lock_q <= lock_req;
                seq_q <= lock_req[1] ? 2'b10 : 2'b01; // see [R3]
            end
        end
    end
    assign mem_o = mem_q;
    assign busy_o = (state_q == SIP_BUSY);
    assign sig_refused_o = refused_q;
    assign lock_level_o = lock_q;
endmodule
`default_nettype wire

// file: sim/sip_pa_asserts.sv
// checker for the page access port
`timescale 1ns/1ps
`default_nettype none
module sip_pa_asserts
    import sip_pkg::*;
#(
    parameter int unsigned ERASE_CYCLES = 100,
    parameter int unsigned WRITE_CYCLES = 50
) (
    // clock, reset and link
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic sck_i,
    input wire logic miso_o,
    // lock selects, array port and status
    input wire logic lock_mode_select_hi_i,
    input wire logic lock_mode_select_lo_i,
    input wire sip_mem_s mem_o,
    input wire logic busy_o,
    input wire logic sig_refused_o,
    input wire logic [1:0] lock_level_o
);
    logic [12:0] last_q;
    logic [15:0] busy_q;
    always_ff @(posedge ref_clk_i) begin
        last_q <= mem_o.req ? mem_o.addr : last_q;
        busy_q <= busy_o ? busy_q + 16'h0001 : 16'h0000;
    end
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!sys_rst_i);
    property p_lock_step;
        $changed(lock_level_o) |-> lock_level_o == $past(lock_level_o) + 2'h1;
    endproperty
    a_lock_step: assert property (p_lock_step) else $error("lock level skipped");
    property p_lock_sel;
        $changed(lock_level_o) |-> lock_level_o == {lock_mode_select_hi_i, lock_mode_select_lo_i};
    endproperty
    a_lock_sel: assert property (p_lock_sel) else $error("lock level not from selects");
    property p_refused;
        $rose(sig_refused_o) |-> lock_level_o != 2'h0;
    endproperty
    a_refused: assert property (p_refused) else $error("refusal while unlocked");
    property p_miso_low;
        $changed(miso_o) |-> !sck_i;
    endproperty
    a_miso_low: assert property (p_miso_low) else $error("data out moved with clock high");
    property p_req_pulse;
        mem_o.req && !mem_o.erase |=> !mem_o.req;
    endproperty
    a_req_pulse: assert property (p_req_pulse) else $error("array request too long");
    property p_addr_next;
        mem_o.req && !mem_o.erase && mem_o.addr[7:0] != 8'h00 |-> mem_o.addr == last_q + 13'h0001;
    endproperty
    a_addr_next: assert property (p_addr_next) else $error("page offset skipped");
    // counter bound only fits the shortened cycle counts of the bench
    property p_busy_len;
        $fell(busy_o) |-> busy_q <= ERASE_CYCLES + 8;
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy too long");
    property p_busy_end;
        $rose(busy_o) |-> ##[1:300] !busy_o;
    endproperty
    a_busy_end: assert property (p_busy_end) else $error("busy never ended");
endmodule
bind sip_page_access sip_pa_asserts #(.ERASE_CYCLES(ERASE_CYCLES), .WRITE_CYCLES(WRITE_CYCLES))
    u_chk (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .sck_i(sck_i), .miso_o(miso_o),
    .lock_mode_select_hi_i(lock_mode_select_hi_i), .lock_mode_select_lo_i(lock_mode_select_lo_i),
    .mem_o(mem_o), .busy_o(busy_o), .sig_refused_o(sig_refused_o), .lock_level_o(lock_level_o));
`default_nettype wire

// file: sim/sip_flash_model.sv
// flash array model behind the memory port
`timescale 1ns/1ps
`default_nettype none
module sip_flash_model
    import sip_pkg::*;
(
    // clock and array port
    input wire logic ref_clk_i,
    input wire sip_mem_s mem_i,
    output logic [7:0] rdata_o
);
    logic [7:0] arr [0:8191];
    always_ff @(posedge ref_clk_i) begin
        if (mem_i.req && mem_i.wr) begin
            arr[mem_i.addr] <= mem_i.wdata;
        end
        // outside a read the data toggles, so a late sample cannot pass
        rdata_o <= (mem_i.req && !mem_i.wr) ? arr[mem_i.addr] : ~rdata_o;
    end
endmodule
`default_nettype wire

// file: sim/testbench.sv
// testbench for the page access port
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import sip_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b0;
    logic sck = 1'b0;
    logic mosi = 1'b0;
    logic sel_hi = 1'b0;
    logic sel_lo = 1'b0;
    logic miso, busy, refused;
    logic [1:0] lvl;
    logic [7:0] rdata, rx;
    sip_mem_s mem;
    int n_errors = 0;
    int n_checks = 0;
    initial forever #12.5 clk = ~clk;
    sip_page_access #(.ERASE_CYCLES(100), .WRITE_CYCLES(50)) dut (.ref_clk_i(clk),
        .sys_rst_i(rst), .sck_i(sck), .mosi_i(mosi), .miso_o(miso),
        .lock_mode_select_hi_i(sel_hi), .lock_mode_select_lo_i(sel_lo), .mem_o(mem),
        .mem_rdata_i(rdata), .signature_i(8'h3C), .busy_o(busy), .sig_refused_o(refused),
        .lock_level_o(lvl));
    sip_flash_model u_flash (.ref_clk_i(clk), .mem_i(mem), .rdata_o(rdata));
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic give_verdict;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // link clock halves of 8 system clocks; it rests low between bytes
    task automatic xfer(input logic [7:0] tx, output logic [7:0] r);
        for (int i = 7; i >= 0; i--) begin
            mosi = tx[i];
            cyc(8);
            r[i] = miso;
            sck = 1'b1;
            cyc(8);
            sck = 1'b0;
        end
    endtask
    task automatic wait_idle;
        int k;
        k = 0;
        while (busy === 1'b1 && k < 400) begin
            cyc(1);
            k++;
        end
        if (k >= 400) begin
            n_errors++;
            give_verdict();
        end
    endtask
    task automatic sig_read(input logic [7:0] exp);
        xfer(CMD_SIG_RD, rx);
        xfer(8'h00, rx);
        xfer(8'h00, rx);
        xfer(8'h00, rx);
        chk("signature", rx, exp);
    endtask
    // erase takes a single byte; the host waits out busy before anything else
    task automatic t_busy;
        xfer(CMD_ERASE, rx);
        cyc(3);
        chk("erase busy", {7'h00, busy}, 8'h01);
        wait_idle();
        xfer(CMD_BYTE_WR, rx);
        xfer(8'h01, rx);
        xfer(8'h00, rx);
        xfer(8'hA5, rx);
        cyc(3);
        chk("write busy", {7'h00, busy}, 8'h01);
        wait_idle();
    endtask
    task automatic t_page;
        xfer(CMD_PAGE_WR, rx);
        xfer(8'h02, rx);
        for (int i = 0; i < 256; i++) xfer(8'(i) ^ 8'h5A, rx);
        xfer(CMD_PAGE_RD, rx);
        xfer(8'h02, rx);
        for (int i = 0; i < 256; i++) begin
            xfer(8'h00, rx);
            chk("page byte", rx, 8'(i) ^ 8'h5A);
        end
        sig_read(8'h3C);
    endtask
    task automatic t_lock;
        logic [1:0] sel [4] = '{2'h1, 2'h3, 2'h2, 2'h3};
        logic [1:0] lvl_exp [4] = '{2'h1, 2'h1, 2'h2, 2'h3};
        for (int i = 0; i < 4; i++) begin
            {sel_hi, sel_lo} = sel[i];
            xfer(CMD_LOCK, rx);
            xfer(8'h00, rx);
            xfer(8'h00, rx);
            xfer(8'h00, rx);
            cyc(4);
            chk("lock level", {6'h00, lvl}, {6'h00, lvl_exp[i]});
        end
        sig_read(SIG_DENIED);
        chk("refused", {7'h00, refused}, 8'h01);
    endtask
    initial begin
        cyc(2);
        rst = 1'b1;
        cyc(70);
        t_busy();
        t_page();
        t_lock();
        give_verdict();
    end
endmodule
`default_nettype wire
